// *** verilog/asrm_readout.sv ***
// Top of the converter serial readout block: mode choice and data output
`timescale 1ns/100ps
`default_nettype none
module asrm_readout
   import asrm_pkg::*;
#(
   parameter int CONV_NS = (CONV_MIN_NS + CONV_MAX_NS) / 2
)
(
   // Clock and reset
   input  wire logic                clock,
   input  wire logic                rst,
   // Serial pins
   input  wire logic                convertStart,
   input  wire logic                serialSelectIn,
   input  wire logic                serialClock,
   output logic                     serialDataOut,
   output logic                     serialDataOutEn,
   // Stand-in for the analog input, same clock domain
   input  wire logic [SAMPLE_W-1:0] sampleCode,
   // Status
   output logic                     chainMode,
   output logic                     busyEnabled,
   output logic                     acquiring
);
   asrm_core_if link ();

   asrm_sync u_sync
   (
      .clock          (clock),
      .rst            (rst),
      .convertStart   (convertStart),
      .serialSelectIn (serialSelectIn),
      .serialClock    (serialClock),
      .link           (link.sync)
   );

   asrm_conv #(
      .CONV_NS (CONV_NS)
   ) u_conv
   (
      .clock (clock),
      .rst   (rst),
      .link  (link.conv)
   );

   asrm_state_e         state;
   logic [SHIFT_W-1:0]  shreg;
   logic [CNT_W-1:0]    fallCnt;
   asrm_state_e         next_state;
   logic [SHIFT_W-1:0]  next_shreg;
   logic [CNT_W-1:0]    next_fallCnt;
   logic                next_dataOut;
   logic                next_dataEn;
   logic                next_chain;
   logic                next_busy;
   logic                next_acq;

   logic                startRise;
   logic                sclkFall;
   logic                selected;
   logic                deselRise;
   logic [CNT_W-1:0]    fallLimit;
   logic [SHIFT_W-1:0]  loadVal;
   logic                doneBusy;

   assign startRise = link.startNow && !link.startLast;
   assign sclkFall  = link.sclkLast && !link.sclkNow;
   // Read gate: convert low (3-wire) or select low (4-wire)
   assign selected  = !(link.startNow && link.selNow);
   assign deselRise = !selected && !(link.startLast && link.selLast);
   assign fallLimit = busyEnabled ? CNT_W'(FALLS_BUSY) :
                                    CNT_W'(FALLS_PLAIN);

   // Select-mode busy decided from pin levels as the conversion finishes; chain keeps its option
   assign doneBusy  = chainMode ? busyEnabled :
                      (!link.startNow || !link.selNow);

   // Start bit ahead of the result, or the result left aligned
   always_comb
   begin
      if (chainMode)
         loadVal = {doneBusy, link.result};
      else if (!doneBusy)
         loadVal = {link.result, 1'h0};
      else
         loadVal = {1'h0, link.result};
   end

   // No new conversion while one runs
   assign link.convStart = startRise && state != ST_CONV;
   assign link.sampleIn  = sampleCode;

   always_comb
   begin
      next_state   = state;
      next_shreg   = shreg;
      next_fallCnt = fallCnt;
      next_dataOut = serialDataOut;
      next_dataEn  = serialDataOutEn;
      next_chain   = chainMode;
      next_busy    = busyEnabled;
      case (state)
         ST_ACQ:
         begin
            // Idle line driven low while both pins are low
            next_dataEn  = !link.startNow && !link.selNow;
            next_dataOut = 1'h0;
         end
         ST_CONV:
         begin
            // Select mode stays released until the end
            if (link.convDone)
            begin
               next_state   = ST_READ;
               next_busy    = doneBusy;
               next_shreg   = loadVal;
               next_fallCnt = '0;
               if (chainMode)
               begin
                  next_dataEn  = 1'h1;
                  // Chain without busy starts one stage lower
                  next_dataOut = doneBusy ? loadVal[SHIFT_W-1] :
                                            loadVal[SHIFT_W-2];
               end
               else
               begin
                  // Busy start bit: high impedance to driven low
                  next_dataEn  = doneBusy;
                  next_dataOut = 1'h0;
               end
            end
         end
         ST_READ:
         begin
            if (chainMode)
            begin
               if (sclkFall)
               begin
                  // Upstream data enters at the bottom
                  next_shreg   = {shreg[SHIFT_W-2:0], link.selNow};
                  // 18 stages per device, one more with busy
                  next_dataOut = busyEnabled ? shreg[SHIFT_W-2] :
                                               shreg[SHIFT_W-3];
               end
               if (!link.startNow)
               begin
                  // Convert low ends the chain frame
                  next_state   = ST_ACQ;
                  next_dataEn  = !link.selNow;
                  next_dataOut = 1'h0;
               end
            end
            else if (deselRise)
            begin
               // Convert or select rising ends the frame
               next_dataEn = 1'h0;
               next_state  = ST_ACQ;
            end
            else if (!serialDataOutEn && selected && fallCnt == '0)
            begin
               // Selection puts the MSB out
               next_dataEn  = 1'h1;
               next_dataOut = shreg[SHIFT_W-1];
            end
            else if (serialDataOutEn && sclkFall)
            begin
               next_fallCnt = fallCnt + CNT_W'(1);
               if (fallCnt + CNT_W'(1) == fallLimit)
               begin
                  // Last fall releases the line
                  next_dataEn = 1'h0;
                  next_state  = ST_ACQ;
               end
               else
               begin
                  // Change only on falls, MSB first
                  next_shreg   = {shreg[SHIFT_W-2:0], 1'h0};
                  next_dataOut = shreg[SHIFT_W-2];
               end
            end
         end
         default:
         begin
            next_state  = ST_ACQ;
            next_dataEn = 1'h0;
         end
      endcase
      if (link.convStart)
      begin
         next_state   = ST_CONV;
         // Level before the edge: tied pins give chain mode
         next_chain   = !link.selLast;
         // Chain busy from serial clock at the edge
         next_busy    = !link.selLast && link.sclkLast;
         next_fallCnt = '0;
         // Select mode releases the line; chain holds it low
         next_dataEn  = !link.selLast;
         next_dataOut = 1'h0;
      end
      // Acquisition, powered down, whenever not converting
      next_acq = (next_state != ST_CONV);
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         state           <= ST_ACQ;
         shreg           <= '0;
         fallCnt         <= '0;
         serialDataOut   <= 1'h0;
         serialDataOutEn <= 1'h0;
         chainMode       <= 1'h0;
         busyEnabled     <= 1'h0;
         acquiring       <= 1'h1;
      end
      else
      begin
         state           <= next_state;
         shreg           <= next_shreg;
         fallCnt         <= next_fallCnt;
         serialDataOut   <= next_dataOut;
         serialDataOutEn <= next_dataEn;
         chainMode       <= next_chain;
         busyEnabled     <= next_busy;
         acquiring       <= next_acq;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);

   sequence s_sel_begin;
      link.convStart && link.selLast;
   endsequence
   sequence s_released;
      !serialDataOutEn [*8];
   endsequence

   property p_mode_pick;
      link.convStart |=> chainMode == !$past(link.selLast) && !acquiring;
   endproperty
   a_mode_pick: assert property (p_mode_pick)
      else $error("mode not taken from select level");

   property p_sel_hiz;
      s_sel_begin |=> s_released;
   endproperty
   a_sel_hiz: assert property (p_sel_hiz)
      else $error("output driven during select conversion");

   property p_chain_busy;
      link.convStart && !link.selLast |=>
         busyEnabled == $past(link.sclkLast);
   endproperty
   a_chain_busy: assert property (p_chain_busy)
      else $error("chain busy option wrong");

   sequence s_busy_done;
      state == ST_CONV && link.convDone && !chainMode && !link.convStart &&
      (!link.startNow || !link.selNow);
   endsequence
   property p_busy_start;
      s_busy_done |=> serialDataOutEn && !serialDataOut && busyEnabled;
   endproperty
   a_busy_start: assert property (p_busy_start)
      else $error("busy start bit missing");

   property p_plain_quiet;
      state == ST_CONV && link.convDone && !chainMode &&
      link.startNow && link.selNow |=> !serialDataOutEn && !busyEnabled;
   endproperty
   a_plain_quiet: assert property (p_plain_quiet)
      else $error("busy enabled with both pins high");

   property p_last_fall;
      state == ST_READ && !chainMode && serialDataOutEn && sclkFall &&
      !deselRise && !link.convStart &&
      fallCnt == fallLimit - CNT_W'(1) |=> !serialDataOutEn;
   endproperty
   a_last_fall: assert property (p_last_fall)
      else $error("line not released on last fall");

   property p_desel;
      state == ST_READ && !chainMode && deselRise && !link.convStart
         |=> !serialDataOutEn && state == ST_ACQ;
   endproperty
   a_desel: assert property (p_desel)
      else $error("line not released on deselect");

   property p_hold;
      state == ST_READ && $past(state) == ST_READ &&
      $past(serialDataOutEn) && !$past(sclkFall) |-> $stable(serialDataOut);
   endproperty
   a_hold: assert property (p_hold)
      else $error("data changed away from a falling edge");

   property p_chain_shift;
      state == ST_READ && chainMode && sclkFall && !link.convStart
         |=> shreg[0] == $past(link.selNow);
   endproperty
   a_chain_shift: assert property (p_chain_shift)
      else $error("chain input not shifted in");

   property p_idle_low;
      state == ST_ACQ && !link.startNow && !link.selNow
         |=> serialDataOutEn && !serialDataOut;
   endproperty
   a_idle_low: assert property (p_idle_low)
      else $error("idle line not driven low");

   property p_power;
      state == ST_CONV && link.convDone |=> acquiring ##1 acquiring;
   endproperty
   a_power: assert property (p_power)
      else $error("no return to acquisition");
endmodule
`default_nettype wire

// *** verilog/asrm_pkg.sv ***
// Constants, timing and state types of the converter serial readout block
package asrm_pkg;
   localparam int RES_W         = 18;
   localparam int SHIFT_W       = RES_W + 1;
   localparam int SAMPLE_W      = 20;
   localparam int FALLS_PLAIN   = RES_W;
   localparam int FALLS_BUSY    = RES_W + 1;
   localparam int CNT_W         = 5;
   localparam logic [RES_W-1:0] CODE_POS_SAT = 18'h1FFFF;
   localparam logic [RES_W-1:0] CODE_NEG_SAT = 18'h20000;
   localparam int CLK_PERIOD_NS = 40;
   localparam int CONV_MIN_NS   = 2000;
   localparam int CONV_MAX_NS   = 4000;
   localparam int CONV_MIN_CYC  =
      (CONV_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CONV_MAX_CYC  = CONV_MAX_NS / CLK_PERIOD_NS;

   typedef enum logic [1:0]
   {
      ST_ACQ  = 2'h0,
      ST_CONV = 2'h1,
      ST_READ = 2'h2
   } asrm_state_e;
endpackage

// *** verilog/asrm_core_if.sv ***
// Interface joining synchroniser, conversion timer and readout control
`timescale 1ns/100ps
`default_nettype none
interface asrm_core_if
   import asrm_pkg::*;
();
   logic             startNow;
   logic             startLast;
   logic             selNow;
   logic             selLast;
   logic             sclkNow;
   logic             sclkLast;
   logic             convStart;
   logic [SAMPLE_W-1:0] sampleIn;
   logic             convDone;
   logic             converting;
   logic [RES_W-1:0] result;

   modport sync
   (
      output startNow, startLast, selNow, selLast, sclkNow, sclkLast
   );
   modport conv
   (
      input  convStart, sampleIn,
      output convDone, converting, result
   );
   modport ctrl
   (
      input  startNow, startLast, selNow, selLast, sclkNow, sclkLast,
      input  convDone, converting, result,
      output convStart, sampleIn
   );
endinterface
`default_nettype wire

// *** verilog/asrm_sync.sv ***
// Two-stage synchronisers and edge history for the three input pins
`timescale 1ns/100ps
`default_nettype none
module asrm_sync
   import asrm_pkg::*;
(
   // Clock and reset
   input  wire logic    clock,
   input  wire logic    rst,
   // Pins
   input  wire logic    convertStart,
   input  wire logic    serialSelectIn,
   input  wire logic    serialClock,
   // Core link
   asrm_core_if.sync    link
);
   logic [2:0] meta;
   logic [2:0] sync;
   logic [2:0] last;
   logic [2:0] next_meta;
   logic [2:0] next_sync;
   logic [2:0] next_last;

   // Only the second stage reads the first
   always_comb
   begin
      next_meta = {convertStart, serialSelectIn, serialClock};
      next_sync = meta;
      next_last = sync;
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         meta <= 3'h0;
         sync <= 3'h0;
         last <= 3'h0;
      end
      else
      begin
         meta <= next_meta;
         sync <= next_sync;
         last <= next_last;
      end
   end

   assign link.startNow  = sync[2];
   assign link.startLast = last[2];
   assign link.selNow    = sync[1];
   assign link.selLast   = last[1];
   assign link.sclkNow   = sync[0];
   assign link.sclkLast  = last[0];
endmodule
`default_nettype wire

// *** verilog/asrm_conv.sv ***
// Internal conversion timer with saturating result coding
`timescale 1ns/100ps
`default_nettype none
module asrm_conv
   import asrm_pkg::*;
#(
   parameter int CONV_NS = (CONV_MIN_NS + CONV_MAX_NS) / 2
)
(
   // Clock and reset
   input  wire logic    clock,
   input  wire logic    rst,
   // Core link
   asrm_core_if.conv    link
);
   localparam int CONV_CYC = (CONV_NS / CLK_PERIOD_NS < 1) ? 1 :
                             CONV_NS / CLK_PERIOD_NS;
   localparam int CW = $clog2(CONV_MAX_CYC + 1);
   localparam logic [CW-1:0] CONV_LOAD = CW'(CONV_CYC);

   // Conversion time must lie between the bounds
   generate
      if (CONV_NS < CONV_MIN_NS || CONV_NS > CONV_MAX_NS ||
          SAMPLE_W < RES_W + 2)
      begin : g_bad
         $error("conversion time or sample width out of range");
      end
   endgenerate

   function automatic logic [RES_W-1:0] satCode
   (
      input logic [SAMPLE_W-1:0] v
   );
      logic [SAMPLE_W-RES_W:0] top;
      top = v[SAMPLE_W-1:RES_W-1];
      if (top == '0 || top == '1)
         satCode = v[RES_W-1:0];
      else if (v[SAMPLE_W-1])
         satCode = CODE_NEG_SAT;
      else
         satCode = CODE_POS_SAT;
   endfunction

   logic [CW-1:0]       cnt;
   logic [SAMPLE_W-1:0] sample;
   logic                done;
   logic [RES_W-1:0]    result;
   logic [CW-1:0]       next_cnt;
   logic [SAMPLE_W-1:0] next_sample;
   logic                next_done;
   logic [RES_W-1:0]    next_result;

   // Counts on the block clock alone; serial clock plays no part
   always_comb
   begin
      next_cnt    = cnt;
      next_sample = sample;
      next_done   = 1'h0;
      next_result = result;
      if (cnt != '0)
      begin
         next_cnt = cnt - CW'(1);
         if (cnt == CW'(1))
         begin
            next_done   = 1'h1;
            next_result = satCode(sample);
         end
      end
      else if (link.convStart)
      begin
         next_cnt    = CONV_LOAD;
         next_sample = link.sampleIn;
      end
   end

   always_ff @(posedge clock or posedge rst)
   begin
      if (rst)
      begin
         cnt    <= '0;
         sample <= '0;
         done   <= 1'h0;
         result <= '0;
      end
      else
      begin
         cnt    <= next_cnt;
         sample <= next_sample;
         done   <= next_done;
         result <= next_result;
      end
   end

   assign link.converting = (cnt != '0);
   assign link.convDone   = done;
   assign link.result     = result;

   property p_conv_time;
      @(posedge clock) disable iff (rst)
      $rose(link.converting) |-> ##[CONV_CYC:CONV_CYC] link.convDone;
   endproperty
   a_conv_time: assert property (p_conv_time)
      else $error("conversion length wrong");

   property p_over_range;
      @(posedge clock) disable iff (rst)
      $rose(link.convDone) && !sample[SAMPLE_W-1] &&
      sample[SAMPLE_W-2:RES_W-1] != '0 |-> link.result == CODE_POS_SAT;
   endproperty
   a_over_range: assert property (p_over_range)
      else $error("over-range code not saturated");
endmodule
`default_nettype wire

// *** tb/asrm_host_model.sv ***
// Host-side model: drives the converter pins and shifts results in
`timescale 1ns/100ps
`default_nettype none
module asrm_host_model
(
   // Block clock used for pacing
   input  wire logic clock,
   // Converter pins
   output var logic  convertStart,
   output var logic  serialSelectIn,
   output var logic  serialClock,
   // Data line as seen through the pull-up
   input  wire logic dataLine
);
   initial
   begin
      convertStart   = 1'b0;
      serialSelectIn = 1'b0;
      serialClock    = 1'b0;
   end

   // Waits whole clocks and returns just after a falling edge
   task automatic idle(input int n);
      repeat (n) @(negedge clock);
   endtask

   // All pin changes land just after a falling block clock edge
   task automatic set_pins(input logic c, input logic s, input logic k);
      @(negedge clock);
      convertStart   = c;
      serialSelectIn = s;
      serialClock    = k;
   endtask

   // Serial clock only runs inside a frame; a long low phase reads slowly
   task automatic read_bits(input int n, input int lowHold,
                            output logic [20:0] bits);
      bits = '0;
      for (int i = 0; i < n; i++)
      begin
         idle(lowHold);
         serialClock = 1'b1;
         idle(4);
         bits = {bits[19:0], dataLine};
         serialClock = 1'b0;
      end
   endtask
endmodule
`default_nettype wire

// *** tb/test_adc_serial_readout_modes.sv ***
// Self-checking bench of the converter serial readout block
`timescale 1ns/100ps
`default_nettype none
module test_adc_serial_readout_modes
   import asrm_pkg::*;
;
   localparam int CONV_NS  = 2000;
   localparam int WAIT_LIM = CONV_MAX_CYC + 20;
   localparam int NROWS    = 8;

   typedef struct
   {
      logic [2:0]          mode;
      logic [SAMPLE_W-1:0] sample;
      logic [RES_W-1:0]    code;
   } asrm_row_s;

   logic                clock;
   logic                rst;
   logic [SAMPLE_W-1:0] sampleCode;
   wire                 convertStart;
   wire                 serialSelectIn;
   wire                 serialClock;
   wire                 dataLine;
   logic                serialDataOut;
   logic                serialDataOutEn;
   logic                chainMode;
   logic                busyEnabled;
   logic                acquiring;
   int                  failures;
   int                  samplesChecked;
   int                  cnt;
   logic [20:0]         got;
   logic                cut;

   // Modes: 0/1 3-wire, 2/3 4-wire, 4/5 chain; odd rows use the busy bit
   asrm_row_s rows [NROWS] = '{
      '{3'h0, 20'h00123, 18'h00123},
      '{3'h1, 20'hFFFFF, 18'h3FFFF},
      '{3'h2, 20'h1FFFF, 18'h1FFFF},
      '{3'h3, 20'h15555, 18'h15555},
      '{3'h4, 20'h20000, 18'h1FFFF},
      '{3'h5, 20'hDFFFF, 18'h20000},
      '{3'h0, 20'hE0000, 18'h20000},
      '{3'h1, 20'hFEDCB, 18'h3EDCB}
   };

   // Single converter on the line with a pull-up, so no contention
   assign dataLine = serialDataOutEn ? serialDataOut : 1'b1;

   asrm_readout #(.CONV_NS(CONV_NS)) u_asrm_readout
   (
      .clock           (clock),
      .rst             (rst),
      .convertStart    (convertStart),
      .serialSelectIn  (serialSelectIn),
      .serialClock     (serialClock),
      .serialDataOut   (serialDataOut),
      .serialDataOutEn (serialDataOutEn),
      .sampleCode      (sampleCode),
      .chainMode       (chainMode),
      .busyEnabled     (busyEnabled),
      .acquiring       (acquiring)
   );

   asrm_host_model u_asrm_host_model
   (
      .clock          (clock),
      .convertStart   (convertStart),
      .serialSelectIn (serialSelectIn),
      .serialClock    (serialClock),
      .dataLine       (dataLine)
   );

   initial clock = 1'b0;
   always #(CLK_PERIOD_NS / 2) clock = ~clock;

   task automatic check(input logic ok, input string what);
      samplesChecked++;
      if (ok !== 1'b1)
      begin
         failures++;
         $display("MISMATCH at %0t: %s", $time, what);
      end
   endtask

   task automatic give_verdict();
      if (failures == 0 && samplesChecked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   task automatic check_reset_state(input logic idleLow);
      check(serialDataOutEn === idleLow && serialDataOut === 1'b0 &&
            chainMode === 1'b0 && busyEnabled === 1'b0 &&
            acquiring === 1'b1, "reset state");
   endtask

   // Waits for the end of conversion; select-mode output stays released
   task automatic wait_done(input logic selMode, output int n);
      n = 0;
      while (acquiring !== 1'b1 && n < WAIT_LIM)
      begin
         if (selMode)
            check(serialDataOutEn === 1'b0, "driven in conversion");
         u_asrm_host_model.idle(1);
         n++;
      end
      if (n >= WAIT_LIM)
      begin
         check(1'b0, "conversion never ended");
         give_verdict();
      end
   endtask

   task automatic run_frame(input asrm_row_s row);
      logic        isChain;
      logic        busy;
      logic        fourWire;
      int          n;
      int          nBits;
      logic [20:0] bits;
      logic [20:0] want;
      isChain  = row.mode >= 3'h4;
      busy     = row.mode[0];
      fourWire = row.mode == 3'h2 || row.mode == 3'h3;
      u_asrm_host_model.set_pins(1'b0, !isChain, isChain & busy);
      sampleCode = row.sample;
      u_asrm_host_model.idle(3);
      u_asrm_host_model.set_pins(1'b1, !isChain, isChain & busy);
      u_asrm_host_model.idle(6);
      check(chainMode === isChain, "mode choice");
      check(acquiring === 1'b0, "conversion not started");
      if (isChain)
         check(busyEnabled === busy, "chain busy option");
      if (isChain)
         u_asrm_host_model.set_pins(1'b1, 1'b1, 1'b0);
      else if (fourWire)
         u_asrm_host_model.set_pins(1'b1, !busy, 1'b0);
      else
      begin
         u_asrm_host_model.set_pins(1'b0, 1'b1, 1'b0);
         u_asrm_host_model.idle(4);
         u_asrm_host_model.set_pins(!busy, 1'b1, 1'b0);
      end
      wait_done(!isChain, n);
      check(n >= CONV_MIN_CYC - 20 && n <= CONV_MAX_CYC, "conv time");
      check(busyEnabled === busy, "busy option");
      if (!busy)
      begin
         u_asrm_host_model.idle(CONV_MAX_CYC - n);
         if (!isChain)
         begin
            check(serialDataOutEn === 1'b0, "driven before select");
            u_asrm_host_model.set_pins(fourWire, !fourWire, 1'b0);
         end
      end
      u_asrm_host_model.idle(4);
      if (!isChain)
         check(serialDataOutEn === 1'b1, "not driven for read");
      nBits = RES_W + int'(busy) + (isChain ? 2 : 0);
      want  = 21'(row.code);
      if (busy)
         want = want | (21'(isChain) << RES_W);
      if (isChain)
         want = (want << 2) | 21'h3;
      u_asrm_host_model.read_bits(nBits, 4, bits);
      check(bits === want, "result bits");
      u_asrm_host_model.idle(6);
      if (!isChain)
         check(serialDataOutEn === 1'b0, "no release");
      u_asrm_host_model.set_pins(1'b0, 1'b0, 1'b0);
      u_asrm_host_model.idle(6);
      check(serialDataOutEn === 1'b1 && serialDataOut === 1'b0,
            "idle line not low");
   endtask

   initial
   begin
      failures       = 0;
      samplesChecked = 0;
      rst            = 1'b1;
      sampleCode     = '0;
      u_asrm_host_model.idle(2);
      check_reset_state(1'b0);
      rst = 1'b0;
      u_asrm_host_model.idle(1);
      check_reset_state(1'b1);
      // Every row of the table converts and reads every bit
      for (int i = 0; i < NROWS; i++)
         run_frame(rows[i]);
      // Readout cut short: 3-wire by convert rise, 4-wire by select rise
      for (int fw = 0; fw < 2; fw++)
      begin
         cut = fw[0];
         u_asrm_host_model.set_pins(1'b0, 1'b1, 1'b0);
         u_asrm_host_model.idle(3);
         u_asrm_host_model.set_pins(1'b1, 1'b1, 1'b0);
         u_asrm_host_model.idle(6);
         wait_done(1'b1, cnt);
         u_asrm_host_model.idle(CONV_MAX_CYC - cnt);
         u_asrm_host_model.set_pins(cut, !cut, 1'b0);
         u_asrm_host_model.idle(4);
         u_asrm_host_model.read_bits(5, 4, got);
         check(got === 21'(rows[NROWS-1].code[RES_W-1 -: 5]),
               "first bits of cut frame");
         u_asrm_host_model.set_pins(1'b1, 1'b1, 1'b0);
         u_asrm_host_model.idle(6);
         check(serialDataOutEn === 1'b0 && acquiring === cut,
               "no release on deselect");
         u_asrm_host_model.idle(6);
         wait_done(1'b1, cnt);
      end
      // Select pin wired to convert start picks chain mode
      for (int t = 0; t < 2; t++)
      begin
         cut = t[0];
         u_asrm_host_model.set_pins(cut, cut, 1'b0);
         u_asrm_host_model.idle(4);
      end
      u_asrm_host_model.idle(2);
      check(chainMode === 1'b1, "tied pins not chain");
      // Reset in mid-conversion
      u_asrm_host_model.idle(10);
      rst = 1'b1;
      u_asrm_host_model.set_pins(1'b0, 1'b0, 1'b0);
      u_asrm_host_model.idle(1);
      check_reset_state(1'b0);
      rst = 1'b0;
      u_asrm_host_model.idle(1);
      check_reset_state(1'b1);
      run_frame(rows[1]);
      give_verdict();
   end
endmodule
`default_nettype wire
